// *** design/erxo_pkg.sv ***
/*
 Constants and carrier types for the receive E3 overhead, data link status block.
 Assumes an 8-bit register port with byte offsets as printed and one frame strobe per received frame.
*/
package erxo_pkg;
    localparam logic [7:0] ADDR_EVENT_STATUS_TWO = 8'h15;
    localparam logic [7:0] ADDR_DL_CONTROL = 8'h18;
    localparam logic [7:0] ADDR_DL_STATE = 8'h19;
    localparam logic [7:0] ADDR_NR_BYTE = 8'h1A;
    localparam logic [7:0] ADDR_GC_BYTE = 8'h1B;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Event status field positions
    localparam int EV_TRACE_CHANGE = 6;
    localparam int EV_FAR_END_BLOCK = 4;
    localparam int EV_FAR_END_FAIL = 3;
    localparam int EV_PARITY = 2;
    localparam int EV_FRAMING = 1;
    localparam int EV_PAYLOAD_TYPE = 0;
    // Data link control fields
    localparam int CTL_SOURCE_SELECT = 3;
    localparam int CTL_RECEIVER_ENABLE = 2;
    localparam int CTL_MESSAGE_IRQ_ENABLE = 1;
    localparam int CTL_MESSAGE_STATUS = 0;
    localparam logic [7:0] CTL_WRITABLE_MASK = 8'h0E;
    // Data link state fields
    localparam int ST_ABORT = 6;
    localparam int ST_KIND_LSB = 4;
    localparam int ST_CMD_RESP = 3;
    localparam int ST_FCS_ERROR = 2;
    localparam int ST_END_OF_MESSAGE = 1;
    localparam int ST_FLAG_PRESENT = 0;
    localparam logic [7:0] FLAG_OCTET = 8'h7E;
    localparam int ABORT_ONES = 7;
    localparam int FAR_END_FAIL_SPAN = 3;

    typedef enum logic [1:0] {
        ERXO_KIND_CL_PATH = 2'h0,
        ERXO_KIND_IDLE = 2'h1,
        ERXO_KIND_TEST = 2'h2,
        ERXO_KIND_ITU_PATH = 2'h3
    } erxo_kind_t;

    // Overhead of one received frame, valid with frame_valid
    typedef struct packed {
        logic frame_valid;
        logic [7:0] trace_byte;
        logic far_end_block_bit;
        logic far_end_fail_bit;
        logic parity_error;
        logic framing_error;
        logic [2:0] payload_type;
        logic [7:0] nr_byte;
        logic [7:0] gc_byte;
    } erxo_frame_t;

    // Result of one whole message from the message receiver
    typedef struct packed {
        logic message_done;
        erxo_kind_t kind;
        logic cmd_resp;
        logic fcs_error;
    } erxo_message_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } erxo_bus_t;
endpackage

// *** design/erxo_status_regs.sv ***
/*
 Receive E3 overhead event status, data link control and state, and NR and GC byte capture.
 Assumes frame and message inputs come from logic on the same clock; the register
 port is a plain strobe port on that clock with read data one cycle after the read strobe.
*/
`timescale 1ns/1ns
module erxo_status_regs (
    input wire logic clock,
    input wire logic srst,
    input wire erxo_pkg::erxo_bus_t bus,
    output logic [7:0] rdata,
    input wire erxo_pkg::erxo_frame_t frame,
    input wire erxo_pkg::erxo_message_t message,
    output logic [7:0] datalink_octet,
    output logic datalink_octet_valid,
    output logic irq
);
    logic [7:0] event_status_reg;
    logic [7:0] event_status_next;
    logic datalink_source_select_reg;
    logic datalink_receiver_enable_reg;
    logic message_irq_enable_reg;
    logic message_status_reg;
    logic [1:0] message_kind_field_reg;
    logic command_response_flag_reg;
    logic frame_check_error_flag_reg;
    logic end_of_message_reg;
    logic flag_present_reg;
    logic abort_reg;
    logic [7:0] network_operator_byte_value_reg;
    logic [7:0] general_channel_byte_reg;
    logic [2:0] prev_payload_type_reg;
    logic payload_seen_reg;
    logic far_end_fail_state_reg;
    logic [1:0] fail_run_reg;
    logic [3:0] ones_run_reg;
    logic [7:0] rdata_reg;
    logic [7:0] dl_octet_reg;
    logic dl_valid_reg;
    logic irq_reg;
    logic [7:0] selected_octet;
    logic fail_toggle;
    logic message_accepted;

    function automatic logic is_read(input erxo_pkg::erxo_bus_t b, input logic [7:0] a);
        is_read = b.rd && (b.addr == a);
    endfunction

    function automatic logic is_write(input erxo_pkg::erxo_bus_t b, input logic [7:0] a);
        is_write = b.wr && (b.addr == a);
    endfunction

    // Source of message octets
    assign selected_octet = datalink_source_select_reg ? frame.nr_byte : frame.gc_byte;
    assign message_accepted = message.message_done && datalink_receiver_enable_reg;

    // A run counts frames disagreeing with the present state; a full run flips it
    assign fail_toggle = frame.frame_valid && (frame.far_end_fail_bit != far_end_fail_state_reg)
        && (fail_run_reg == 2'(erxo_pkg::FAR_END_FAIL_SPAN - 1));

    always_ff @(posedge clock) begin
        if (srst) begin
            far_end_fail_state_reg <= 1'b0;
            fail_run_reg <= 2'h0;
        end else if (frame.frame_valid) begin
            if (frame.far_end_fail_bit == far_end_fail_state_reg) begin
                fail_run_reg <= 2'h0;
            end else if (fail_toggle) begin
                far_end_fail_state_reg <= ~far_end_fail_state_reg;
                fail_run_reg <= 2'h0;
            end else begin
                fail_run_reg <= fail_run_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            prev_payload_type_reg <= 3'h0;
            payload_seen_reg <= 1'b0;
        end else if (frame.frame_valid) begin
            prev_payload_type_reg <= frame.payload_type;
            payload_seen_reg <= 1'b1;
        end
    end

    // Events set after the read clear so an event in the read cycle survives
    always_comb begin
        event_status_next = event_status_reg;
        if (is_read(bus, erxo_pkg::ADDR_EVENT_STATUS_TWO)) begin
            event_status_next = erxo_pkg::RESET_BYTE;
        end
        if (frame.frame_valid) begin
            if (frame.trace_byte[7]) begin
                event_status_next[erxo_pkg::EV_TRACE_CHANGE] = 1'b1;
            end
            if (frame.far_end_block_bit) begin
                event_status_next[erxo_pkg::EV_FAR_END_BLOCK] = 1'b1;
            end
            if (fail_toggle) begin
                event_status_next[erxo_pkg::EV_FAR_END_FAIL] = 1'b1;
            end
            if (frame.parity_error) begin
                event_status_next[erxo_pkg::EV_PARITY] = 1'b1;
            end
            if (frame.framing_error) begin
                event_status_next[erxo_pkg::EV_FRAMING] = 1'b1;
            end
            if (payload_seen_reg && (frame.payload_type != prev_payload_type_reg)) begin
                event_status_next[erxo_pkg::EV_PAYLOAD_TYPE] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            event_status_reg <= erxo_pkg::RESET_BYTE;
        end else begin
            event_status_reg <= event_status_next;
        end
    end

    // Control: only bits 3..1 are writable
    always_ff @(posedge clock) begin
        if (srst) begin
            datalink_source_select_reg <= 1'b0;
            datalink_receiver_enable_reg <= 1'b0;
            message_irq_enable_reg <= 1'b0;
        end else if (is_write(bus, erxo_pkg::ADDR_DL_CONTROL)) begin
            datalink_source_select_reg <= bus.wdata[erxo_pkg::CTL_SOURCE_SELECT];
            datalink_receiver_enable_reg <= bus.wdata[erxo_pkg::CTL_RECEIVER_ENABLE];
            message_irq_enable_reg <= bus.wdata[erxo_pkg::CTL_MESSAGE_IRQ_ENABLE];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            message_status_reg <= 1'b0;
        end else if (message_accepted) begin
            message_status_reg <= 1'b1;
        end else if (is_read(bus, erxo_pkg::ADDR_DL_CONTROL)) begin
            message_status_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            end_of_message_reg <= 1'b0;
        end else if (message_accepted) begin
            end_of_message_reg <= 1'b1;
        end else if (is_read(bus, erxo_pkg::ADDR_DL_STATE)) begin
            end_of_message_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            message_kind_field_reg <= 2'h0;
            command_response_flag_reg <= 1'b0;
            frame_check_error_flag_reg <= 1'b0;
        end else if (message_accepted) begin
            message_kind_field_reg <= message.kind;
            command_response_flag_reg <= message.cmd_resp;
            frame_check_error_flag_reg <= message.fcs_error;
        end
    end

    // Channel watch: flag octet and run of ones on the selected byte, MSB first
    always_ff @(posedge clock) begin
        if (srst) begin
            flag_present_reg <= 1'b0;
            abort_reg <= 1'b0;
            ones_run_reg <= 4'h0;
        end else if (frame.frame_valid) begin
            flag_present_reg <= datalink_receiver_enable_reg
                && (selected_octet == erxo_pkg::FLAG_OCTET);
            if (selected_octet == 8'hFF) begin
                if (ones_run_reg < 4'(erxo_pkg::ABORT_ONES)) begin
                    ones_run_reg <= ones_run_reg + 4'h8 > 4'(erxo_pkg::ABORT_ONES)
                        ? 4'(erxo_pkg::ABORT_ONES) : ones_run_reg + 4'h8;
                end
                abort_reg <= datalink_receiver_enable_reg;
            end else begin
                ones_run_reg <= 4'h0;
                abort_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            network_operator_byte_value_reg <= erxo_pkg::RESET_BYTE;
            general_channel_byte_reg <= erxo_pkg::RESET_BYTE;
        end else if (frame.frame_valid) begin
            network_operator_byte_value_reg <= frame.nr_byte;
            general_channel_byte_reg <= frame.gc_byte;
        end
    end

    // Octets handed to the message receiver only while it is enabled
    always_ff @(posedge clock) begin
        if (srst) begin
            dl_octet_reg <= erxo_pkg::RESET_BYTE;
            dl_valid_reg <= 1'b0;
        end else begin
            dl_valid_reg <= frame.frame_valid && datalink_receiver_enable_reg;
            if (frame.frame_valid) begin
                dl_octet_reg <= selected_octet;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (message_status_reg || message_accepted) && message_irq_enable_reg;
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_reg <= erxo_pkg::RESET_BYTE;
        end else if (bus.rd) begin
            case (bus.addr)
                erxo_pkg::ADDR_EVENT_STATUS_TWO: rdata_reg <= event_status_reg & 8'h5F;
                erxo_pkg::ADDR_DL_CONTROL: rdata_reg <= {4'h0, datalink_source_select_reg,
                    datalink_receiver_enable_reg, message_irq_enable_reg, message_status_reg};
                erxo_pkg::ADDR_DL_STATE: rdata_reg <= {1'b0, abort_reg, message_kind_field_reg,
                    command_response_flag_reg, frame_check_error_flag_reg, end_of_message_reg,
                    flag_present_reg};
                erxo_pkg::ADDR_NR_BYTE: rdata_reg <= network_operator_byte_value_reg;
                erxo_pkg::ADDR_GC_BYTE: rdata_reg <= general_channel_byte_reg;
                default: rdata_reg <= erxo_pkg::RESET_BYTE;
            endcase
        end else begin
            rdata_reg <= erxo_pkg::RESET_BYTE;
        end
    end

    assign rdata = rdata_reg;
    assign datalink_octet = dl_octet_reg;
    assign datalink_octet_valid = dl_valid_reg;
    assign irq = irq_reg;
endmodule

// *** verif/erxo_status_checker.sv ***
/*
 Port assertions for the receive overhead and data link status block.
 Assumes the bind below onto erxo_status_regs, one clock and a synchronous reset.
*/
`timescale 1ns/1ns
module erxo_status_checker (
    input wire logic clock,
    input wire logic srst,
    input wire erxo_pkg::erxo_bus_t bus,
    input wire logic [7:0] rdata,
    input wire erxo_pkg::erxo_frame_t frame,
    input wire erxo_pkg::erxo_message_t message,
    input wire logic [7:0] datalink_octet,
    input wire logic datalink_octet_valid,
    input wire logic irq
);
    logic [2:0] ctl_reg;
    // Shadow of source select, receiver enable and irq enable, on the design's own edge
    always_ff @(posedge clock) begin
        if (srst) begin
            ctl_reg <= 3'h0;
        end else if (bus.wr && bus.addr == 8'h18) begin
            ctl_reg <= bus.wdata[3:1];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // Quiet read: no frame lands in the same cycle to muddy the value
    sequence rd_quiet(logic [7:0] a);
        bus.rd && bus.addr == a && !frame.frame_valid;
    endsequence
    // The bench reads the status two cycles after the frame strobe
    property ev_seen(logic c, int b);
        frame.frame_valid && c ##2 rd_quiet(8'h15) |=> rdata[b];
    endproperty
    trace_event_a: assert property (ev_seen(frame.trace_byte[7], 6)) else $error("trace change missed");
    block_error_a: assert property (ev_seen(frame.far_end_block_bit, 4)) else $error("febe missed");
    parity_event_a: assert property (ev_seen(frame.parity_error, 2)) else $error("parity missed");
    framing_event_a: assert property (ev_seen(frame.framing_error, 1)) else $error("framing missed");
    clear_read_a: assert property (rd_quiet(8'h15) ##1 !frame.frame_valid ##1 rd_quiet(8'h15) |=> rdata == 8'h00)
        else $error("status not cleared by read");
    octet_enable_a: assert property (frame.frame_valid |=> datalink_octet_valid == $past(ctl_reg[1]))
        else $error("octet valid wrong");
    octet_source_a: assert property (frame.frame_valid && ctl_reg[1] |=>
        datalink_octet == ($past(ctl_reg[2]) ? $past(frame.nr_byte) : $past(frame.gc_byte)))
        else $error("octet from wrong byte");
    irq_gate_a: assert property (!ctl_reg[0] |=> !irq) else $error("irq while disabled");
    irq_raise_a: assert property (message.message_done && ctl_reg == 3'h3 || message.message_done &&
        ctl_reg == 3'h7 |=> irq) else $error("irq not raised");
    nr_capture_a: assert property (frame.frame_valid ##4 rd_quiet(8'h1A) |=> rdata == $past(frame.nr_byte, 5))
        else $error("nr byte stale");
    message_state_a: assert property (message.message_done && ctl_reg[1] ##5 rd_quiet(8'h19) |=>
        rdata[5:1] == {$past(message.kind, 6), $past(message.cmd_resp, 6), $past(message.fcs_error, 6), 1'b1})
        else $error("message state wrong");
    ctl_status_a: assert property (message.message_done && ctl_reg[1] ##3 rd_quiet(8'h18) |=>
        rdata[3:0] == {$past(ctl_reg), 1'b1}) else $error("message status wrong");
    unused_bits_a: assert property (rd_quiet(8'h18) |=> rdata[7:4] == 4'h0) else $error("unused bits set");
endmodule

bind erxo_status_regs erxo_status_checker u_chk (.clock(clock), .srst(srst), .bus(bus), .rdata(rdata),
    .frame(frame), .message(message), .datalink_octet(datalink_octet),
    .datalink_octet_valid(datalink_octet_valid), .irq(irq));

// *** verif/erxo_far_end.sv ***
/*
 Behavioural remote terminal: hands over one frame's overhead or one message result per call.
 Assumes the caller keeps calls apart; the fields start at zero and carry inverted junk after each strobe.
*/
`timescale 1ns/1ns
module erxo_far_end (
    input wire logic clock,
    output erxo_pkg::erxo_frame_t frame,
    output erxo_pkg::erxo_message_t message
);
    initial begin
        frame = '0;
        message = '0;
    end
    task automatic send_frame(input erxo_pkg::erxo_frame_t f);
        erxo_pkg::erxo_frame_t junk;
        f.frame_valid = 1'b1;
        junk = ~f;
        junk.frame_valid = 1'b0;
        @(posedge clock);
        frame <= f;
        @(posedge clock);
        frame <= junk;
    endtask
    task automatic send_msg(input erxo_pkg::erxo_kind_t k, input logic cr, input logic fcs);
        @(posedge clock);
        message <= '{1'b1, k, cr, fcs};
        @(posedge clock);
        message <= '{1'b0, erxo_pkg::erxo_kind_t'(~k), ~cr, ~fcs};
    endtask
endmodule

// *** verif/tb.sv ***
/*
 Self-checking bench for the receive overhead and data link status block.
 Assumes the remote terminal model and the bound checker beside the design.
*/
`timescale 1ns/1ns
module tb;
    logic clock;
    logic srst;
    erxo_pkg::erxo_bus_t bus;
    erxo_pkg::erxo_frame_t frame;
    erxo_pkg::erxo_message_t message;
    logic [7:0] rdata;
    logic [7:0] datalink_octet;
    logic datalink_octet_valid;
    logic irq;
    logic [7:0] d;
    int n_fail;
    int num_checks;
    // Row: frame overhead word then expected event status
    logic [39:0] rows [9] = '{40'h8902ABCD00, 40'hC002112240, 40'h8062334410, 40'h8032556604,
        40'h802A77880A, 40'h8025991201, 40'h80055A3400, 40'h80056B4500, 40'hFF853C5648};
    logic [7:0] ro_addr [6] = '{8'h15, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h16};
    logic [15:0] fl [3] = '{16'h7E01, 16'hFF40, 16'h3C00};
    erxo_status_regs u_dut (.clock(clock), .srst(srst), .bus(bus), .rdata(rdata), .frame(frame),
        .message(message), .datalink_octet(datalink_octet), .datalink_octet_valid(datalink_octet_valid), .irq(irq));
    erxo_far_end u_far (.clock(clock), .frame(frame), .message(message));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '{a, v, 1'b0, 1'b0};
    endtask
    task rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
        q = rdata;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
    initial begin
        n_fail = 0;
        num_checks = 0;
        bus = '0;
        srst = 1'b1;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        wr(8'h1A, 8'h55);
        wr(8'h15, 8'hFF);
        wr(8'h19, 8'hFF);
        foreach (ro_addr[i]) begin
            rd(ro_addr[i], d);
            chk("reset value", 8'h00, d);
        end
        wr(8'h18, 8'hFF);
        rd(8'h18, d);
        chk("control mask", 8'h0E, d);
        for (int i = 0; i < 9; i++) begin
            u_far.send_frame(erxo_pkg::erxo_frame_t'(rows[i][39:8]));
            #1;
            chk("octet valid", 8'h01, {7'h00, datalink_octet_valid});
            chk("octet", rows[i][23:16], datalink_octet);
            rd(8'h15, d);
            chk("event status", rows[i][7:0], d);
            rd(8'h1A, d);
            chk("nr byte", rows[i][23:16], d);
            rd(8'h1B, d);
            chk("gc byte", rows[i][15:8], d);
        end
        rd(8'h15, d);
        chk("status after read", 8'h00, d);
        rd(8'h15, d);
        chk("status reread", 8'h00, d);
        for (int j = 0; j < 3; j++) begin
            u_far.send_frame({16'h8005, fl[j][15:8], 8'h00});
            rd(8'h19, d);
            chk("flag and abort", fl[j][7:0], d);
        end
        for (int k = 0; k < 4; k++) begin
            u_far.send_msg(erxo_pkg::erxo_kind_t'(k), k[0], k[1]);
            @(posedge clock);
            #1;
            chk("irq", 8'h01, {7'h00, irq});
            rd(8'h18, d);
            chk("control status", 8'h0F, d);
            rd(8'h19, d);
            chk("message state", {2'b00, k[1:0], k[0], k[1], 2'b10}, d);
            rd(8'h19, d);
            chk("state cleared", {2'b00, k[1:0], k[0], k[1], 2'b00}, d);
            chk("irq cleared", 8'h00, {7'h00, irq});
        end
        // Receiver off: frames must raise no octet valid and messages must leave the data link state as it was
        wr(8'h18, 8'h08);
        u_far.send_frame(32'h80057E00);
        #1;
        chk("octet valid off", 8'h00, {7'h00, datalink_octet_valid});
        u_far.send_msg(erxo_pkg::ERXO_KIND_CL_PATH, 1'b0, 1'b0);
        rd(8'h19, d);
        chk("state when off", 8'h3C, d);
        wr(8'h18, 8'h04);
        u_far.send_frame(32'h8005115A);
        #1;
        chk("gc octet", 8'h5A, datalink_octet);
        u_far.send_msg(erxo_pkg::ERXO_KIND_IDLE, 1'b0, 1'b0);
        repeat (2) @(posedge clock);
        #1;
        chk("irq masked", 8'h00, {7'h00, irq});
        rd(8'h18, d);
        chk("status masked", 8'h05, d);
        give_verdict();
    end
endmodule
